// ===== vud_pkg.sv
// Constants, register map and types of the undervoltage decoupling and reconnection block
package vud_pkg;
   // Clock and time base
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned TICK_MS = 1;
   localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam logic [9:0] MS_PER_S = 10'h3E8;
   // Decoupling delay figure and the undervoltage ratio 17/20 = 0.85
   localparam logic [15:0] T_DECOUPLE_MS = 16'h01F4;
   localparam logic [7:0] UV_RATIO_NUM = 8'h11;
   localparam logic [7:0] UV_RATIO_DEN = 8'h14;
   // Register word offsets (byte addresses)
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_VNOM = 8'h04;
   localparam logic [7:0] OFS_IMIN = 8'h08;
   localparam logic [7:0] OFS_QMIN = 8'h0C;
   localparam logic [7:0] OFS_TANPHI = 8'h10;
   localparam logic [7:0] OFS_T1 = 8'h14;
   localparam logic [7:0] OFS_T2 = 8'h18;
   localparam logic [7:0] OFS_TBLOCK = 8'h1C;
   localparam logic [7:0] OFS_TQUAL = 8'h20;
   localparam logic [7:0] OFS_FLO = 8'h24;
   localparam logic [7:0] OFS_FHI = 8'h28;
   localparam logic [7:0] OFS_VLO = 8'h2C;
   localparam logic [7:0] OFS_VHI = 8'h30;
   localparam logic [7:0] OFS_STATUS = 8'h34;
   localparam logic [7:0] OFS_TRIGMASK = 8'h38;
   // Control field positions
   localparam int CTRL_ENABLE = 0;
   localparam int CTRL_METHOD = 1;
   localparam int CTRL_IMIN_EN = 2;
   localparam int CTRL_DIR_INV = 3;
   localparam int CTRL_RCOND_LO = 4;
   localparam int CTRL_REMOTE_EN = 6;
   localparam int CTRL_STG1_EN = 7;
   localparam int CTRL_STG2_EN = 8;
   // Reset values
   localparam logic [15:0] RST_CTRL = 16'h0181;
   localparam logic [15:0] RST_VNOM = 16'h2710;
   localparam logic [15:0] RST_IMIN = 16'h0064;
   localparam logic [15:0] RST_QMIN = 16'h0064;
   localparam logic [15:0] RST_TANPHI = 16'h0100;
   localparam logic [15:0] RST_TBLOCK_S = 16'h0258;
   localparam logic [15:0] RST_TQUAL_S = 16'h012C;
   localparam logic [15:0] RST_FLO_MHZ = 16'hB98C;
   localparam logic [15:0] RST_FHI_MHZ = 16'hC92C;
   localparam logic [15:0] RST_VLO = 16'h2486;
   localparam logic [15:0] RST_VHI = 16'h319C;
   localparam logic [5:0] RST_TRIGMASK = 6'h3F;
   // Selector encodings
   localparam logic [1:0] RCOND_INTERNAL = 2'h0;
   localparam logic [1:0] RCOND_EXTERNAL = 2'h1;
   localparam logic [1:0] RCOND_BOTH = 2'h2;
   typedef enum logic [1:0] {
      RC_BLOCK = 2'b00,
      RC_WAIT = 2'b01,
      RC_RELEASE = 2'b10
   } vud_rc_state_type;
endpackage

// ===== vud_core.sv
// Reactive-power undervoltage decoupling with reconnection release and Avalon-MM registers
//
// Behaviour
// [RULE1] Trip once undervoltage plus inductive demand has persisted 0.5 s.
// [RULE2] Undervoltage only when all three line voltages are below 0.85 of nominal.
// [RULE3] Reactive demand uses positive-sequence reactive power.
// [RULE4] Undervoltage supervision uses only phase-to-phase voltages.
// [RULE5] Selector picks power angle or pure reactive power detection.
// [RULE6] Low positive-sequence current suppresses reactive demand detection.
// [RULE7] Angle method always checks minimum current and compares angle with setting.
// [RULE8] Pure method compares reactive power with threshold; current check optional.
// [RULE9] Two independent delay stages both start at pick-up.
// [RULE10] Reconnection starts from six decoupling elements and other triggers, ORed.
// [RULE11] Release held off for a blocking interval after any trigger, default ten minutes.
// [RULE12] Release needs voltage and frequency in band continuously for set time.
// [RULE13] Reconnection uses mains phase-to-phase voltage and mains frequency.
// [RULE14] Release condition selector: internal, external, or both.
// [RULE15] Both choice requires internal and remote release together.
// [RULE16] Remote enable gates the remote release input.
// [RULE17] Coupling point drives remote release only once its voltage is restored.
// [RULE18] Frequency and voltage bands configurable to high-voltage figures.
// [RULE19] Qualification time configurable to at least five minutes.
// [RULE20] Leaving band before blocking ends restarts the blocking timer.
// [RULE21] Direction setting inverts reactive power sign inside this element only.
// [RULE22] Delay timers clear when pick-up drops before expiry.
// [RULE23] New trigger during release drops release and restarts blocking.
`timescale 1ns/10ps
module vud_core #(
   parameter int unsigned TICK_CYCLES = vud_pkg::TICK_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [15:0] v_l12,
   input wire logic [15:0] v_l23,
   input wire logic [15:0] v_l31,
   input wire logic [15:0] mains_freq,
   input wire logic [15:0] i_pos_seq,
   input wire logic signed [15:0] p_pos_seq,
   input wire logic signed [15:0] q_pos_seq,
   input wire logic [5:0] decouple_trig,
   input wire logic [2:0] aux_trig,
   input wire logic remote_release_input,
   output logic decouple_trip,
   output logic decouple_trip2,
   output logic reconnect_release
);
   ////////////////////////////////////////////////////////////////////////////
   logic ack_q;
   logic [7:0] byte_addr;
   logic wr_en;
   logic [15:0] ctrl_q;
   logic [15:0] vnom_q;
   logic [15:0] min_pos_seq_current_q;
   logic [15:0] var_pickup_threshold_q;
   logic [15:0] tanphi_q;
   logic [15:0] t1_q;
   logic [15:0] t2_q;
   logic [15:0] tblock_q;
   logic [15:0] tqual_q;
   logic [15:0] flo_q;
   logic [15:0] fhi_q;
   logic [15:0] vlo_q;
   logic [15:0] vhi_q;
   logic [5:0] trigmask_q;
   logic [31:0] rd_d;
   logic [31:0] rd_q;
   logic [15:0] status;

   assign byte_addr = {avs_address, 2'b00};
   // Every access stalls one cycle so read data always comes from a flop
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   assign wr_en = avs_write & ack_q;
   assign avs_readdata = rd_q;

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
      logic [15:0] r;
      r = old;
      if (be[0]) begin
         r[7:0] = wd[7:0];
      end
      if (be[1]) begin
         r[15:8] = wd[15:8];
      end
      return r;
   endfunction

   always_ff @(posedge clk) begin
      if (rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (avs_read | avs_write) & ~ack_q;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_q <= vud_pkg::RST_CTRL;
         vnom_q <= vud_pkg::RST_VNOM;
         min_pos_seq_current_q <= vud_pkg::RST_IMIN;
         var_pickup_threshold_q <= vud_pkg::RST_QMIN;
         tanphi_q <= vud_pkg::RST_TANPHI;
         t1_q <= vud_pkg::T_DECOUPLE_MS;
         t2_q <= vud_pkg::T_DECOUPLE_MS;
         tblock_q <= vud_pkg::RST_TBLOCK_S;
         tqual_q <= vud_pkg::RST_TQUAL_S;
         flo_q <= vud_pkg::RST_FLO_MHZ;
         fhi_q <= vud_pkg::RST_FHI_MHZ;
         vlo_q <= vud_pkg::RST_VLO;
         vhi_q <= vud_pkg::RST_VHI;
         trigmask_q <= vud_pkg::RST_TRIGMASK;
      end else if (wr_en) begin
         case (byte_addr)
            vud_pkg::OFS_CTRL: ctrl_q <= merge16(ctrl_q, avs_writedata, avs_byteenable);
            vud_pkg::OFS_VNOM: vnom_q <= merge16(vnom_q, avs_writedata, avs_byteenable);
            vud_pkg::OFS_IMIN: begin
               min_pos_seq_current_q <= merge16(min_pos_seq_current_q, avs_writedata, avs_byteenable);
            end
            vud_pkg::OFS_QMIN: begin
               var_pickup_threshold_q <= merge16(var_pickup_threshold_q, avs_writedata, avs_byteenable);
            end
            vud_pkg::OFS_TANPHI: tanphi_q <= merge16(tanphi_q, avs_writedata, avs_byteenable);
            vud_pkg::OFS_T1: t1_q <= merge16(t1_q, avs_writedata, avs_byteenable);
            vud_pkg::OFS_T2: t2_q <= merge16(t2_q, avs_writedata, avs_byteenable);
            vud_pkg::OFS_TBLOCK: tblock_q <= merge16(tblock_q, avs_writedata, avs_byteenable); // [RULE11]
            vud_pkg::OFS_TQUAL: tqual_q <= merge16(tqual_q, avs_writedata, avs_byteenable); // [RULE19]
            vud_pkg::OFS_FLO: flo_q <= merge16(flo_q, avs_writedata, avs_byteenable); // [RULE18]
            vud_pkg::OFS_FHI: fhi_q <= merge16(fhi_q, avs_writedata, avs_byteenable); // [RULE18]
            vud_pkg::OFS_VLO: vlo_q <= merge16(vlo_q, avs_writedata, avs_byteenable); // [RULE18]
            vud_pkg::OFS_VHI: vhi_q <= merge16(vhi_q, avs_writedata, avs_byteenable); // [RULE18]
            vud_pkg::OFS_TRIGMASK: begin
               if (avs_byteenable[0]) begin
                  trigmask_q <= avs_writedata[5:0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_comb begin
      rd_d = 32'h00000000;
      case (byte_addr)
         vud_pkg::OFS_CTRL: rd_d[15:0] = ctrl_q;
         vud_pkg::OFS_VNOM: rd_d[15:0] = vnom_q;
         vud_pkg::OFS_IMIN: rd_d[15:0] = min_pos_seq_current_q;
         vud_pkg::OFS_QMIN: rd_d[15:0] = var_pickup_threshold_q;
         vud_pkg::OFS_TANPHI: rd_d[15:0] = tanphi_q;
         vud_pkg::OFS_T1: rd_d[15:0] = t1_q;
         vud_pkg::OFS_T2: rd_d[15:0] = t2_q;
         vud_pkg::OFS_TBLOCK: rd_d[15:0] = tblock_q;
         vud_pkg::OFS_TQUAL: rd_d[15:0] = tqual_q;
         vud_pkg::OFS_FLO: rd_d[15:0] = flo_q;
         vud_pkg::OFS_FHI: rd_d[15:0] = fhi_q;
         vud_pkg::OFS_VLO: rd_d[15:0] = vlo_q;
         vud_pkg::OFS_VHI: rd_d[15:0] = vhi_q;
         vud_pkg::OFS_STATUS: rd_d[15:0] = status;
         vud_pkg::OFS_TRIGMASK: rd_d[5:0] = trigmask_q;
         default: rd_d = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_q <= 32'h00000000;
      end else if (avs_read & ~ack_q) begin
         rd_q <= rd_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Time base: millisecond and second enable pulses
   logic [16:0] div_q;
   logic [9:0] ms_q;
   logic ms_tick;
   logic sec_tick;

   assign ms_tick = (div_q == 17'(TICK_CYCLES - 1));
   assign sec_tick = ms_tick & (ms_q == vud_pkg::MS_PER_S - 10'h001);

   always_ff @(posedge clk) begin
      if (rst) begin
         div_q <= 17'h00000;
      end else if (ms_tick) begin
         div_q <= 17'h00000;
      end else begin
         div_q <= div_q + 17'h00001;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ms_q <= 10'h000;
      end else if (sec_tick) begin
         ms_q <= 10'h000;
      end else if (ms_tick) begin
         ms_q <= ms_q + 10'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pick-up: undervoltage AND inductive reactive demand
   logic [15:0] v_ll [3];
   logic [2:0] uv_ph;
   logic uv_all;
   logic signed [16:0] q_eff;
   logic [15:0] p_abs;
   logic q_pos;
   logic imin_ok;
   logic angle_dem;
   logic pure_dem;
   logic var_dem;
   logic pickup;

   // Phase-to-phase only, so a displaced neutral cannot fake a sag
   assign v_ll[0] = v_l12; // [RULE4]
   assign v_ll[1] = v_l23;
   assign v_ll[2] = v_l31;

   generate
      for (genvar g = 0; g < 3; g++) begin : g_uv
         assign uv_ph[g] = (24'(v_ll[g]) * 24'(vud_pkg::UV_RATIO_DEN))
                           < (24'(vnom_q) * 24'(vud_pkg::UV_RATIO_NUM)); // [RULE2]
      end
   endgenerate

   assign uv_all = &uv_ph; // [RULE2]
   // Sign flip is local; the input q_pos_seq itself is untouched
   assign q_eff = ctrl_q[vud_pkg::CTRL_DIR_INV] ? -17'(q_pos_seq) : 17'(q_pos_seq); // [RULE21] [RULE3]
   assign p_abs = p_pos_seq[15] ? 16'(-17'(p_pos_seq)) : 16'(p_pos_seq);
   assign q_pos = q_eff > 17'sh00000;
   assign imin_ok = i_pos_seq >= min_pos_seq_current_q; // [RULE6]
   // Angle beyond setting: q*256 > |p|*tan(phi), tan in 8.8 fixed point
   assign angle_dem = q_pos & imin_ok
                      & ({8'h00, q_eff[15:0], 8'h00} > (32'(p_abs) * 32'(tanphi_q))); // [RULE7]
   assign pure_dem = (q_eff > $signed({1'b0, var_pickup_threshold_q}))
                     & (imin_ok | ~ctrl_q[vud_pkg::CTRL_IMIN_EN]); // [RULE8]
   assign var_dem = ctrl_q[vud_pkg::CTRL_METHOD] ? pure_dem : angle_dem; // [RULE5]
   assign pickup = ctrl_q[vud_pkg::CTRL_ENABLE] & uv_all & var_dem;

   ////////////////////////////////////////////////////////////////////////////
   // Two delay stages, both started by the same pick-up
   logic [15:0] stg_cnt_q [2];
   logic [1:0] stg_trip_q;
   logic [15:0] stg_dly [2];
   logic [1:0] stg_en;

   assign stg_dly[0] = t1_q;
   assign stg_dly[1] = t2_q;
   assign stg_en = {ctrl_q[vud_pkg::CTRL_STG2_EN], ctrl_q[vud_pkg::CTRL_STG1_EN]};

   generate
      for (genvar s = 0; s < 2; s++) begin : g_stage
         always_ff @(posedge clk) begin
            if (rst) begin
               stg_cnt_q[s] <= 16'h0000;
               stg_trip_q[s] <= 1'b0;
            end else if (!pickup || !stg_en[s]) begin
               stg_cnt_q[s] <= 16'h0000; // [RULE22]
               stg_trip_q[s] <= 1'b0;
            end else if (ms_tick && !stg_trip_q[s]) begin
               if (stg_cnt_q[s] + 16'h0001 >= stg_dly[s]) begin
                  stg_trip_q[s] <= 1'b1; // [RULE1] [RULE9]
               end else begin
                  stg_cnt_q[s] <= stg_cnt_q[s] + 16'h0001; // [RULE9]
               end
            end
         end
      end
   endgenerate

   assign decouple_trip = stg_trip_q[0];
   assign decouple_trip2 = stg_trip_q[1];

   ////////////////////////////////////////////////////////////////////////////
   // Reconnection release
   logic trig;
   logic f_ok;
   logic [2:0] v_ok;
   logic in_band;
   logic [15:0] qual_q;
   logic qual_ok;
   logic ext_ok;
   logic cond_ok;
   logic [15:0] blk_q;
   vud_pkg::vud_rc_state_type rc_q;
   vud_pkg::vud_rc_state_type rc_d;

   assign trig = (|(decouple_trig & trigmask_q)) | (|aux_trig) | (|stg_trip_q); // [RULE10]
   assign f_ok = (mains_freq >= flo_q) & (mains_freq <= fhi_q); // [RULE13]

   generate
      for (genvar b = 0; b < 3; b++) begin : g_band
         assign v_ok[b] = (v_ll[b] >= vlo_q) & (v_ll[b] <= vhi_q); // [RULE13]
      end
   endgenerate

   assign in_band = f_ok & (&v_ok);

   always_ff @(posedge clk) begin
      if (rst) begin
         qual_q <= 16'h0000;
      end else if (!in_band) begin
         qual_q <= 16'h0000; // [RULE12]
      end else if (sec_tick && !qual_ok) begin
         qual_q <= qual_q + 16'h0001;
      end
   end

   assign qual_ok = in_band & (qual_q >= tqual_q); // [RULE12]
   // Remote signal counts only when its enable is set; the far end asserts it on restored voltage
   assign ext_ok = ctrl_q[vud_pkg::CTRL_REMOTE_EN] & remote_release_input; // [RULE16] [RULE17]

   always_comb begin
      case (ctrl_q[vud_pkg::CTRL_RCOND_LO +: 2]) // [RULE14]
         vud_pkg::RCOND_INTERNAL: cond_ok = qual_ok;
         vud_pkg::RCOND_EXTERNAL: cond_ok = ext_ok;
         vud_pkg::RCOND_BOTH: cond_ok = qual_ok & ext_ok; // [RULE15]
         default: cond_ok = 1'b0;
      endcase
   end

   always_comb begin
      rc_d = rc_q;
      case (rc_q)
         vud_pkg::RC_BLOCK: begin
            if (!trig && in_band && sec_tick && (blk_q + 16'h0001 >= tblock_q)) begin
               rc_d = vud_pkg::RC_WAIT; // [RULE11]
            end
         end
         vud_pkg::RC_WAIT: begin
            if (trig) begin
               rc_d = vud_pkg::RC_BLOCK;
            end else if (cond_ok) begin
               rc_d = vud_pkg::RC_RELEASE;
            end
         end
         vud_pkg::RC_RELEASE: begin
            if (trig) begin
               rc_d = vud_pkg::RC_BLOCK; // [RULE23]
            end else if (!cond_ok) begin
               rc_d = vud_pkg::RC_WAIT;
            end
         end
         default: rc_d = vud_pkg::RC_BLOCK;
      endcase
   end

   // Blocked after reset too: nothing is released until the mains has proved itself
   always_ff @(posedge clk) begin
      if (rst) begin
         rc_q <= vud_pkg::RC_BLOCK;
      end else begin
         rc_q <= rc_d;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         blk_q <= 16'h0000;
      end else if (trig || rc_q != vud_pkg::RC_BLOCK) begin
         blk_q <= 16'h0000; // [RULE11] [RULE23]
      end else if (!in_band) begin
         blk_q <= 16'h0000; // [RULE20]
      end else if (sec_tick) begin
         blk_q <= blk_q + 16'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         reconnect_release <= 1'b0;
      end else begin
         reconnect_release <= (rc_d == vud_pkg::RC_RELEASE); // [RULE23]
      end
   end

   assign status = {6'h00, rc_q, reconnect_release, qual_ok, in_band, stg_trip_q, pickup, var_dem, uv_all};
endmodule // vud_core

// ===== vud_core_assertions.sv
// Port-level concurrent checks for the decoupling and reconnection block
`timescale 1ns/10ps
module vud_core_assertions #(
   parameter int unsigned TICK_CYCLES = vud_pkg::TICK_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic [15:0] v_l12,
   input wire logic [15:0] v_l23,
   input wire logic [15:0] v_l31,
   input wire logic [5:0] decouple_trig,
   input wire logic [2:0] aux_trig,
   input wire logic decouple_trip,
   input wire logic decouple_trip2,
   input wire logic reconnect_release
);
   int unsigned uv_cnt;
   int unsigned quiet_cnt;
   logic uv;
   // Nominal left at reset: v*20 below 10000*17 means v below 8500
   assign uv = (v_l12 < 16'h2134) && (v_l23 < 16'h2134) && (v_l31 < 16'h2134);
   always_ff @(posedge clk) begin
      if (rst || !uv) uv_cnt <= 0;
      else if (uv_cnt < 32'h0010_0000) uv_cnt <= uv_cnt + 1;
   end
   // Valid only while the blocking time is set to 2 s or more
   always_ff @(posedge clk) begin
      if (rst || (|decouple_trig) || (|aux_trig) || decouple_trip || decouple_trip2) quiet_cnt <= 0;
      else if (quiet_cnt < 32'h0010_0000) quiet_cnt <= quiet_cnt + 1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("waitrequest held for more than one cycle");
   a_wait_fresh: assert property ((avs_read || avs_write) && !avs_waitrequest ##1 (avs_read || avs_write)
      |-> avs_waitrequest) else $error("new request answered without a wait cycle");
   a_trip_delay: assert property ($rose(decouple_trip) |-> uv_cnt >= 498 * TICK_CYCLES)
      else $error("stage one tripped before the decoupling delay");
   a_trip2_delay: assert property ($rose(decouple_trip2) |-> uv_cnt >= 498 * TICK_CYCLES)
      else $error("stage two tripped before its delay");
   a_trip_drop: assert property (!uv [*3] |-> !decouple_trip && !decouple_trip2)
      else $error("trip held without undervoltage on all lines");
   a_release_drop: assert property ((|decouple_trig) || (|aux_trig) |-> ##2 !reconnect_release)
      else $error("release kept after a decoupling trigger");
   a_release_own: assert property (decouple_trip || decouple_trip2 |=> !reconnect_release)
      else $error("release kept during own trip");
   a_release_block: assert property ($rose(reconnect_release) |-> quiet_cnt >= 1000 * TICK_CYCLES - 4)
      else $error("release granted inside the blocking interval");
endmodule // vud_core_assertions

bind vud_core vud_core_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clk(clk), .rst(rst),
   .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .v_l12(v_l12),
   .v_l23(v_l23), .v_l31(v_l31), .decouple_trig(decouple_trig), .aux_trig(aux_trig),
   .decouple_trip(decouple_trip), .decouple_trip2(decouple_trip2), .reconnect_release(reconnect_release));

// ===== vud_mains_model.sv
// Behavioural mains side: line voltages, frequency, sequence quantities and remote release
`timescale 1ns/10ps
module vud_mains_model (
   input wire logic [2:0] sag,
   input wire logic in_band,
   input wire logic [15:0] i_set,
   input wire logic signed [15:0] q_set,
   input wire logic rem_req,
   output logic [15:0] v_l12,
   output logic [15:0] v_l23,
   output logic [15:0] v_l31,
   output logic [15:0] mains_freq,
   output logic [15:0] i_pos_seq,
   output logic signed [15:0] p_pos_seq,
   output logic signed [15:0] q_pos_seq,
   output logic remote_release_input
);
   // Only line-to-line values exist here, so neutral shift never reaches the block
   assign v_l12 = sag[0] ? 16'h1F40 : 16'h2710;
   assign v_l23 = sag[1] ? 16'h1F40 : 16'h2710;
   assign v_l31 = sag[2] ? 16'h1F40 : 16'h2710;
   assign mains_freq = in_band ? 16'hC350 : 16'hCB20;
   assign i_pos_seq = i_set;
   assign p_pos_seq = 16'sh0064;
   assign q_pos_seq = q_set;
   // The coupling point never signals release while its own voltage is unhealthy
   assign remote_release_input = rem_req && in_band && (sag == 3'h0);
endmodule // vud_mains_model

// ===== vud_core_bench.sv
// Self-checking bench for the decoupling and reconnection block
`timescale 1ns/10ps
module vud_core_bench;
   localparam int unsigned TICKS = 4;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [5:0] avs_address = 6'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [15:0] v_l12, v_l23, v_l31, mains_freq, i_pos_seq;
   logic signed [15:0] p_pos_seq, q_pos_seq;
   logic [5:0] decouple_trig = 6'h00;
   logic [2:0] aux_trig = 3'h0;
   logic remote_release_input, decouple_trip, decouple_trip2, reconnect_release;
   logic [2:0] sag = 3'h0;
   logic in_band = 1'b1;
   logic [15:0] i_set = 16'h00C8;
   logic signed [15:0] q_set = 16'sh0000;
   logic rem_req = 1'b0;
   logic [31:0] rd;
   int error_cnt = 0;
   int tests_run = 0;
   logic [5:0] r_adr [0:7] = '{6'h00, 6'h01, 6'h07, 6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0F};
   logic [15:0] r_val [0:7] = '{16'h0181, 16'h2710, 16'h0258, 16'h012C, 16'hB98C, 16'hC92C, 16'h2486, 16'h0000};
   // Angle, two lines only, low current, capacitive, inverted sign, pure, pure with current check, small Q
   logic [15:0] c_ctrl [0:7] = '{16'h0181, 16'h0181, 16'h0181, 16'h0181, 16'h0189, 16'h0183, 16'h0187, 16'h0183};
   logic [2:0] c_sag [0:7] = '{3'h7, 3'h3, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7};
   logic [15:0] c_i [0:7] = '{16'h00C8, 16'h00C8, 16'h0032, 16'h00C8, 16'h00C8, 16'h0032, 16'h0032, 16'h00C8};
   logic [15:0] c_q [0:7] = '{16'h012C, 16'h012C, 16'h012C, 16'hFED4, 16'hFED4, 16'h012C, 16'h012C, 16'h0032};
   logic c_exp [0:7] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
   // Last entry selects the unused release condition, which must never release
   logic [15:0] e_ctrl [0:6] = '{16'h01D1, 16'h01D1, 16'h0191, 16'h01E1, 16'h01E1, 16'h01A1, 16'h01F1};
   logic e_rem [0:6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
   logic e_exp [0:6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};

   always #4 clk = ~clk;

   vud_core #(.TICK_CYCLES(TICKS)) dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .v_l12(v_l12), .v_l23(v_l23), .v_l31(v_l31), .mains_freq(mains_freq),
      .i_pos_seq(i_pos_seq), .p_pos_seq(p_pos_seq), .q_pos_seq(q_pos_seq), .decouple_trig(decouple_trig),
      .aux_trig(aux_trig), .remote_release_input(remote_release_input), .decouple_trip(decouple_trip),
      .decouple_trip2(decouple_trip2), .reconnect_release(reconnect_release));
   vud_mains_model u_mains (.sag(sag), .in_band(in_band), .i_set(i_set), .q_set(q_set), .rem_req(rem_req),
      .v_l12(v_l12), .v_l23(v_l23), .v_l31(v_l31), .mains_freq(mains_freq), .i_pos_seq(i_pos_seq),
      .p_pos_seq(p_pos_seq), .q_pos_seq(q_pos_seq), .remote_release_input(remote_release_input));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      // Waitrequest as it stood at each rising edge; only the watchdog ends a hang
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic setm(input logic [2:0] s, input logic [15:0] i, input logic [15:0] q);
      @(posedge clk);
      sag <= s;
      i_set <= i;
      q_set <= q;
   endtask
   task automatic wrel(input int lim);
      int n;
      n = 0;
      while (reconnect_release !== 1'b1 && n < lim) begin
         @(negedge clk);
         n++;
      end
      chk(32'(reconnect_release), 32'h1);
   endtask
   task automatic results();
      $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (90000) @(posedge clk);
      error_cnt++;
      results();
   end

   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int k = 0; k < 8; k++) begin
         bus(1'b0, r_adr[k], 32'h0);
         chk(rd, {16'h0, r_val[k]});
      end
      // Short blocking and qualification times keep the run brief
      bus(1'b1, 6'h07, 32'h2);
      bus(1'b1, 6'h08, 32'h1);
      bus(1'b0, 6'h07, 32'h0);
      chk(rd, 32'h2);
      setm(3'h7, 16'h00C8, 16'h012C);
      cyc(1200);
      setm(3'h0, 16'h00C8, 16'h012C);
      cyc(8);
      setm(3'h7, 16'h00C8, 16'h012C);
      cyc(1980);
      chk(32'(decouple_trip), 32'h0);
      cyc(40);
      chk(32'({decouple_trip, decouple_trip2}), 32'h3);
      setm(3'h0, 16'h00C8, 16'h0000);
      cyc(4);
      for (int k = 0; k < 8; k++) begin
         bus(1'b1, 6'h00, {16'h0, c_ctrl[k]});
         setm(c_sag[k], c_i[k], c_q[k]);
         cyc(2020);
         chk(32'({decouple_trip, decouple_trip2}), {30'h0, c_exp[k], c_exp[k]});
         setm(3'h0, 16'h00C8, 16'h0000);
         cyc(4);
         chk(32'(decouple_trip), 32'h0);
      end
      bus(1'b1, 6'h00, 32'h0181);
      wrel(12000);
      for (int k = 0; k < 2; k++) begin
         @(posedge clk);
         if (k == 0) decouple_trig <= 6'h20;
         else aux_trig <= 3'h4;
         @(posedge clk);
         decouple_trig <= 6'h00;
         aux_trig <= 3'h0;
         cyc(2);
         chk(32'(reconnect_release), 32'h0);
         cyc(3900);
         chk(32'(reconnect_release), 32'h0);
         wrel(12000);
      end
      for (int k = 0; k < 7; k++) begin
         bus(1'b1, 6'h00, {16'h0, e_ctrl[k]});
         @(posedge clk);
         rem_req <= e_rem[k];
         cyc(6);
         chk(32'(reconnect_release), {31'h0, e_exp[k]});
      end
      // Band glitches during blocking push the release past its unrestarted limit
      bus(1'b1, 6'h00, 32'h01D1);
      @(posedge clk);
      rem_req <= 1'b1;
      aux_trig <= 3'h1;
      @(posedge clk);
      aux_trig <= 3'h0;
      for (int k = 0; k < 3; k++) begin
         cyc(2500);
         in_band <= 1'b0;
         cyc(10);
         in_band <= 1'b1;
      end
      cyc(1500);
      chk(32'(reconnect_release), 32'h0);
      wrel(12000);
      results();
   end
endmodule // vud_core_bench
